// [rtcc_pkg.sv]
package rtcc_pkg;

    // register byte offsets
    localparam logic [4:0] RTCC_OFF_CTRL = 5'h00;
    localparam logic [4:0] RTCC_OFF_ALARM = 5'h04;
    localparam logic [4:0] RTCC_OFF_TIME = 5'h08;
    localparam logic [4:0] RTCC_OFF_DATE = 5'h0c;
    localparam logic [4:0] RTCC_OFF_ATIME = 5'h10;

    // control register fields
    localparam int RTCC_CTRL_ON_BIT = 15;
    localparam int RTCC_CTRL_WREN_BIT = 3;
    localparam logic [31:0] RTCC_CTRL_MASK = 32'h0000_8008;

    // alarm control fields
    localparam int RTCC_ALM_EN_BIT = 15;
    localparam int RTCC_ALM_CHIME_BIT = 14;
    localparam int RTCC_ALM_SYNC_BIT = 12;
    localparam int RTCC_ALM_MASK_LSB = 8;
    localparam logic [31:0] RTCC_ALM_WMASK = 32'h0000_cfff;

    // implemented bits of time and date words
    localparam logic [31:0] RTCC_TIME_MASK = 32'h3f7f_7f00;
    localparam logic [31:0] RTCC_DATE_MASK = 32'hff1f_3f07;

    // reset values
    localparam logic [31:0] RTCC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RTCC_ALM_RST = 32'h0000_0000;
    localparam logic [31:0] RTCC_ATIME_RST = 32'h0000_0000;
    localparam logic [31:0] RTCC_TIME_RST = 32'h0000_0000;
    localparam logic [31:0] RTCC_DATE_RST = 32'h0001_0100;
    localparam logic [7:0] RTCC_RPT_RST = 8'h00;
    localparam logic [7:0] RTCC_RPT_MAX = 8'hff;

    // time base
    localparam int RTCC_CLK_HZ = 200_000_000;
    localparam int RTCC_HALF_SEC_CYC = RTCC_CLK_HZ / 2;
    // sync flag window around the half-second rollover, in clocks
    localparam int RTCC_SYNC_WIN_CYC = 32;

    // alarm mask codes
    typedef enum logic [3:0] {
        RTCC_AM_HALF = 4'h0,
        RTCC_AM_SEC = 4'h1,
        RTCC_AM_10SEC = 4'h2,
        RTCC_AM_MIN = 4'h3,
        RTCC_AM_10MIN = 4'h4,
        RTCC_AM_HOUR = 4'h5,
        RTCC_AM_DAY = 4'h6,
        RTCC_AM_WEEK = 4'h7,
        RTCC_AM_MONTH = 4'h8,
        RTCC_AM_YEAR = 4'h9
    } rtcc_amask_t;

    typedef struct packed {
        logic [1:0] hours_tens;
        logic [3:0] hours_ones;
        logic [2:0] minutes_tens;
        logic [3:0] minutes_ones;
        logic [2:0] seconds_tens;
        logic [3:0] seconds_ones;
    } rtcc_time_t;

    typedef struct packed {
        logic [3:0] years_tens;
        logic [3:0] years_ones;
        logic months_tens;
        logic [3:0] months_ones;
        logic [1:0] days_tens;
        logic [3:0] days_ones;
        logic [2:0] weekday_value;
    } rtcc_date_t;

endpackage

// [rtcc_digit.sv]
`timescale 1ns/100ps
// one bcd digit pair: advances by one with a programmable terminal value
module rtcc_digit (
    // current pair
    input wire logic [3:0] tens_i,
    input wire logic [3:0] ones_i,
    // limits
    input wire logic [3:0] last_tens_i,
    input wire logic [3:0] last_ones_i,
    input wire logic [3:0] first_ones_i,
    // advance
    input wire logic inc_i,
    output logic [3:0] tens_o,
    output logic [3:0] ones_o,
    output logic carry_o
);
    wire at_last = (tens_i == last_tens_i) && (ones_i == last_ones_i);
    wire ones_wrap = (ones_i == 4'h9);

    assign carry_o = inc_i && at_last;
    assign tens_o = !inc_i ? tens_i : at_last ? 4'h0 : ones_wrap ? tens_i + 4'h1 : tens_i;
    assign ones_o = !inc_i ? ones_i : at_last ? first_ones_i : ones_wrap ? 4'h0 : ones_i + 4'h1;
endmodule

// [rtcc_core.sv]
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - repeat count N makes the alarm fire N+1 times; 0xff gives 256.
// - each alarm event at a nonzero count decrements the repeat count by one.
// - at zero, an event wraps the count to 0xff only in chime mode.
// - event at count zero without chime clears alarm enable.
// - time bits 29-28 hold hours tens, 27-24 hours ones, in bcd.
// - time bits 22-20 hold minutes tens, 19-16 minutes ones, in bcd.
// - time bits 14-12 hold seconds tens, 11-8 seconds ones, in bcd.
// - time bits 31-30, 23, 15 and 7-0 read as zero.
// - time and date writes take effect only while clock write enable set.
// - date bits 31-28 hold years tens, 27-24 years ones, in bcd.
// - date bit 20 holds months tens, bits 19-16 months ones.
// - date bits 13-12 hold days tens, 11-8 days ones.
// - date bits 2-0 hold weekday, ranging 0 to 6.
// - without chime the count stops at zero; chime repeats forever.
module rtcc_core #(
    parameter int HALF_SEC_CYC = rtcc_pkg::RTCC_HALF_SEC_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // status
    output logic alarm_event_o
);
    // field positions inside the control words
    localparam int ON = rtcc_pkg::RTCC_CTRL_ON_BIT;
    localparam int WREN = rtcc_pkg::RTCC_CTRL_WREN_BIT;
    localparam int EN = rtcc_pkg::RTCC_ALM_EN_BIT;
    localparam int CHIME = rtcc_pkg::RTCC_ALM_CHIME_BIT;
    localparam int SYNC = rtcc_pkg::RTCC_ALM_SYNC_BIT;
    localparam int MLSB = rtcc_pkg::RTCC_ALM_MASK_LSB;

    // prescaler limits; a half second shorter than two windows keeps the flag set
    localparam logic [31:0] HALF_LAST = 32'(HALF_SEC_CYC - 1);
    localparam logic [31:0] SYNC_LO = 32'(rtcc_pkg::RTCC_SYNC_WIN_CYC);
    localparam logic [31:0] SYNC_HI = 32'(HALF_SEC_CYC - rtcc_pkg::RTCC_SYNC_WIN_CYC);

    // reset values split into digit fields
    localparam rtcc_pkg::rtcc_time_t TIME_RST = '{
        hours_tens: rtcc_pkg::RTCC_TIME_RST[29:28],
        hours_ones: rtcc_pkg::RTCC_TIME_RST[27:24],
        minutes_tens: rtcc_pkg::RTCC_TIME_RST[22:20],
        minutes_ones: rtcc_pkg::RTCC_TIME_RST[19:16],
        seconds_tens: rtcc_pkg::RTCC_TIME_RST[14:12],
        seconds_ones: rtcc_pkg::RTCC_TIME_RST[11:8]
    };
    localparam rtcc_pkg::rtcc_date_t DATE_RST = '{
        years_tens: rtcc_pkg::RTCC_DATE_RST[31:28],
        years_ones: rtcc_pkg::RTCC_DATE_RST[27:24],
        months_tens: rtcc_pkg::RTCC_DATE_RST[20],
        months_ones: rtcc_pkg::RTCC_DATE_RST[19:16],
        days_tens: rtcc_pkg::RTCC_DATE_RST[13:12],
        days_ones: rtcc_pkg::RTCC_DATE_RST[11:8],
        weekday_value: rtcc_pkg::RTCC_DATE_RST[2:0]
    };

    // state
    logic [31:0] ctrl_q;
    logic [31:0] alm_q;
    logic [31:0] alm_d;
    logic [31:0] atime_q;
    rtcc_pkg::rtcc_time_t time_q;
    rtcc_pkg::rtcc_time_t time_tick;
    rtcc_pkg::rtcc_time_t time_d;
    rtcc_pkg::rtcc_date_t date_q;
    rtcc_pkg::rtcc_date_t date_tick;
    rtcc_pkg::rtcc_date_t date_d;
    logic [31:0] presc_q;
    logic half_q;

    // bus decode; a write lands on the edge that sees ack high
    wire bus_hit = cyc_i && stb_i;
    wire bus_first = bus_hit && !ack_o;
    wire wr_go = bus_hit && ack_o && we_i;
    wire [31:0] byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire wr_ctrl = wr_go && (adr_i == rtcc_pkg::RTCC_OFF_CTRL);
    wire wr_alm = wr_go && (adr_i == rtcc_pkg::RTCC_OFF_ALARM);
    wire wr_time = wr_go && (adr_i == rtcc_pkg::RTCC_OFF_TIME);
    wire wr_date = wr_go && (adr_i == rtcc_pkg::RTCC_OFF_DATE);
    wire wr_atime = wr_go && (adr_i == rtcc_pkg::RTCC_OFF_ATIME);

    // control bits
    wire clock_on = ctrl_q[ON];
    wire clock_write_enable = ctrl_q[WREN];
    wire wr_time_ok = wr_time && clock_write_enable;
    wire wr_date_ok = wr_date && clock_write_enable;

    // register words as software sees them
    wire [31:0] time_word = {
        2'h0, time_q.hours_tens, time_q.hours_ones,
        1'b0, time_q.minutes_tens, time_q.minutes_ones,
        1'b0, time_q.seconds_tens, time_q.seconds_ones,
        8'h00
    };
    wire [31:0] date_word = {
        date_q.years_tens, date_q.years_ones,
        3'h0, date_q.months_tens, date_q.months_ones,
        2'h0, date_q.days_tens, date_q.days_ones,
        5'h00, date_q.weekday_value
    };

    // byte-lane merge of write data, unimplemented bits dropped
    wire [31:0] ctrl_wr_word = ((ctrl_q & ~byte_mask) | (dat_i & byte_mask))
        & rtcc_pkg::RTCC_CTRL_MASK;
    wire [31:0] alm_wr_word = ((alm_q & ~byte_mask) | (dat_i & byte_mask))
        & rtcc_pkg::RTCC_ALM_WMASK;
    wire [31:0] atime_wr_word = ((atime_q & ~byte_mask) | (dat_i & byte_mask))
        & rtcc_pkg::RTCC_TIME_MASK;
    wire [31:0] time_wr_word = ((time_word & ~byte_mask) | (dat_i & byte_mask))
        & rtcc_pkg::RTCC_TIME_MASK;
    wire [31:0] date_wr_word = ((date_word & ~byte_mask) | (dat_i & byte_mask))
        & rtcc_pkg::RTCC_DATE_MASK;

    // written words split into digits
    wire rtcc_pkg::rtcc_time_t time_wr = '{
        hours_tens: time_wr_word[29:28],
        hours_ones: time_wr_word[27:24],
        minutes_tens: time_wr_word[22:20],
        minutes_ones: time_wr_word[19:16],
        seconds_tens: time_wr_word[14:12],
        seconds_ones: time_wr_word[11:8]
    };
    wire rtcc_pkg::rtcc_date_t date_wr = '{
        years_tens: date_wr_word[31:28],
        years_ones: date_wr_word[27:24],
        months_tens: date_wr_word[20],
        months_ones: date_wr_word[19:16],
        days_tens: date_wr_word[13:12],
        days_ones: date_wr_word[11:8],
        weekday_value: date_wr_word[2:0]
    };
    wire rtcc_pkg::rtcc_time_t atime = '{
        hours_tens: atime_q[29:28],
        hours_ones: atime_q[27:24],
        minutes_tens: atime_q[22:20],
        minutes_ones: atime_q[19:16],
        seconds_tens: atime_q[14:12],
        seconds_ones: atime_q[11:8]
    };

    // time base: half-second ticks, every second one advances the clock
    wire half_tick = clock_on && (presc_q == HALF_LAST);
    wire sec_tick = half_tick && half_q;
    wire sync_now = clock_on && ((presc_q < SYNC_LO) || (presc_q >= SYNC_HI));

    // digit chain outputs
    logic [3:0] sec_t;
    logic [3:0] sec_o;
    logic [3:0] min_t;
    logic [3:0] min_o;
    logic [3:0] hr_t;
    logic [3:0] hr_o;
    logic [3:0] day_t;
    logic [3:0] day_o;
    logic [3:0] mon_t;
    logic [3:0] mon_o;
    logic [3:0] yr_t;
    logic [3:0] yr_o;
    logic sec_c;
    logic min_c;
    logic hr_c;
    logic day_c;
    logic mon_c;

    // month length, leap years by the two-digit year only
    wire [3:0] mon_ones = date_q.months_ones;
    wire [3:0] yr_ones = date_q.years_ones;
    wire is_feb = !date_q.months_tens && (mon_ones == 4'h2);
    wire is_short = date_q.months_tens ? (mon_ones == 4'h1)
        : ((mon_ones == 4'h4) || (mon_ones == 4'h6) || (mon_ones == 4'h9));
    wire is_leap = date_q.years_tens[0] ? ((yr_ones == 4'h2) || (yr_ones == 4'h6))
        : ((yr_ones == 4'h0) || (yr_ones == 4'h4) || (yr_ones == 4'h8));
    wire [3:0] day_last_t = is_feb ? 4'h2 : 4'h3;
    wire [3:0] day_last_o = is_feb ? (is_leap ? 4'h9 : 4'h8) : (is_short ? 4'h0 : 4'h1);
    wire [2:0] wday_next = (date_q.weekday_value == 3'h6) ? 3'h0
        : date_q.weekday_value + 3'h1;

    rtcc_digit u_sec (
        .tens_i({1'b0, time_q.seconds_tens}),
        .ones_i(time_q.seconds_ones),
        .last_tens_i(4'h5),
        .last_ones_i(4'h9),
        .first_ones_i(4'h0),
        .inc_i(sec_tick),
        .tens_o(sec_t),
        .ones_o(sec_o),
        .carry_o(sec_c)
    );

    rtcc_digit u_min (
        .tens_i({1'b0, time_q.minutes_tens}),
        .ones_i(time_q.minutes_ones),
        .last_tens_i(4'h5),
        .last_ones_i(4'h9),
        .first_ones_i(4'h0),
        .inc_i(sec_c),
        .tens_o(min_t),
        .ones_o(min_o),
        .carry_o(min_c)
    );

    rtcc_digit u_hour (
        .tens_i({2'h0, time_q.hours_tens}),
        .ones_i(time_q.hours_ones),
        .last_tens_i(4'h2),
        .last_ones_i(4'h3),
        .first_ones_i(4'h0),
        .inc_i(min_c),
        .tens_o(hr_t),
        .ones_o(hr_o),
        .carry_o(hr_c)
    );

    rtcc_digit u_day (
        .tens_i({2'h0, date_q.days_tens}),
        .ones_i(date_q.days_ones),
        .last_tens_i(day_last_t),
        .last_ones_i(day_last_o),
        .first_ones_i(4'h1),
        .inc_i(hr_c),
        .tens_o(day_t),
        .ones_o(day_o),
        .carry_o(day_c)
    );

    rtcc_digit u_month (
        .tens_i({3'h0, date_q.months_tens}),
        .ones_i(date_q.months_ones),
        .last_tens_i(4'h1),
        .last_ones_i(4'h2),
        .first_ones_i(4'h1),
        .inc_i(day_c),
        .tens_o(mon_t),
        .ones_o(mon_o),
        .carry_o(mon_c)
    );

    // the century is not kept, so the year carry goes nowhere
    rtcc_digit u_year (
        .tens_i(date_q.years_tens),
        .ones_i(date_q.years_ones),
        .last_tens_i(4'h9),
        .last_ones_i(4'h9),
        .first_ones_i(4'h0),
        .inc_i(mon_c),
        .tens_o(yr_t),
        .ones_o(yr_o),
        .carry_o()
    );

    // next time and date; a software write beats a tick in the same cycle
    always_comb begin
        time_tick = time_q;
        time_tick.seconds_tens = sec_t[2:0];
        time_tick.seconds_ones = sec_o;
        time_tick.minutes_tens = min_t[2:0];
        time_tick.minutes_ones = min_o;
        time_tick.hours_tens = hr_t[1:0];
        time_tick.hours_ones = hr_o;
    end

    always_comb begin
        date_tick = date_q;
        date_tick.days_tens = day_t[1:0];
        date_tick.days_ones = day_o;
        date_tick.months_tens = mon_t[0];
        date_tick.months_ones = mon_o;
        date_tick.years_tens = yr_t;
        date_tick.years_ones = yr_o;
        if (hr_c) begin
            date_tick.weekday_value = wday_next;
        end
    end

    assign time_d = wr_time_ok ? time_wr : time_tick;
    assign date_d = wr_date_ok ? date_wr : date_tick;

    // alarm compare against the time that the tick is about to load
    wire [3:0] alarm_mask = alm_q[MLSB +: 4];
    wire [7:0] alarm_repeat_count = alm_q[7:0];
    wire alarm_enable = alm_q[EN];
    wire m_sec_o = time_tick.seconds_ones == atime.seconds_ones;
    wire m_sec = m_sec_o && (time_tick.seconds_tens == atime.seconds_tens);
    wire m_min_o = time_tick.minutes_ones == atime.minutes_ones;
    wire m_min = m_min_o && (time_tick.minutes_tens == atime.minutes_tens);
    wire m_hr = (time_tick.hours_ones == atime.hours_ones)
        && (time_tick.hours_tens == atime.hours_tens);
    logic mask_hit;

    // with no alarm date kept, the day-and-longer masks fall back to a daily match
    always_comb begin
        mask_hit = 1'b0;
        unique case (alarm_mask)
            rtcc_pkg::RTCC_AM_HALF: mask_hit = half_tick;
            rtcc_pkg::RTCC_AM_SEC: mask_hit = sec_tick;
            rtcc_pkg::RTCC_AM_10SEC: mask_hit = sec_tick && m_sec_o;
            rtcc_pkg::RTCC_AM_MIN: mask_hit = sec_tick && m_sec;
            rtcc_pkg::RTCC_AM_10MIN: mask_hit = sec_tick && m_sec && m_min_o;
            rtcc_pkg::RTCC_AM_HOUR: mask_hit = sec_tick && m_sec && m_min;
            rtcc_pkg::RTCC_AM_DAY,
            rtcc_pkg::RTCC_AM_WEEK,
            rtcc_pkg::RTCC_AM_MONTH,
            rtcc_pkg::RTCC_AM_YEAR: mask_hit = sec_tick && m_sec && m_min && m_hr;
            // reserved codes never fire
            default: mask_hit = 1'b0;
        endcase
    end

    wire fire = alarm_enable && mask_hit;

    // repeat counter; software rewrites the whole word if it writes in the same cycle
    always_comb begin
        alm_d = alm_q;
        if (fire) begin
            if (alarm_repeat_count != 8'h00) begin
                alm_d[7:0] = alarm_repeat_count - 8'h01;
            end else if (alm_q[CHIME]) begin
                alm_d[7:0] = rtcc_pkg::RTCC_RPT_MAX;
            end else begin
                alm_d[EN] = 1'b0;
            end
        end
        if (wr_alm) begin
            alm_d = alm_wr_word;
        end
    end

    // read mux; the sync flag is live, not stored
    wire [31:0] sync_word = sync_now ? (32'h0000_0001 << SYNC) : 32'h0000_0000;
    logic [31:0] rd_word;

    always_comb begin
        unique case (adr_i)
            rtcc_pkg::RTCC_OFF_CTRL: rd_word = ctrl_q;
            rtcc_pkg::RTCC_OFF_ALARM: rd_word = alm_q | sync_word;
            rtcc_pkg::RTCC_OFF_TIME: rd_word = time_word;
            rtcc_pkg::RTCC_OFF_DATE: rd_word = date_word;
            rtcc_pkg::RTCC_OFF_ATIME: rd_word = atime_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // bus answer: ack one cycle after the request, dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_first;
            if (bus_first) begin
                dat_o <= rd_word;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= rtcc_pkg::RTCC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_wr_word;
        end
    end

    // switching the module off restarts the half-second phase
    always_ff @(posedge clk_i) begin
        if (rst_i || !clock_on) begin
            presc_q <= 32'h0000_0000;
            half_q <= 1'b0;
        end else if (half_tick) begin
            presc_q <= 32'h0000_0000;
            half_q <= !half_q;
        end else begin
            presc_q <= presc_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            time_q <= TIME_RST;
            date_q <= DATE_RST;
        end else begin
            time_q <= time_d;
            date_q <= date_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alm_q <= rtcc_pkg::RTCC_ALM_RST;
            atime_q <= rtcc_pkg::RTCC_ATIME_RST;
            alarm_event_o <= 1'b0;
        end else begin
            alm_q <= alm_d;
            alarm_event_o <= fire;
            if (wr_atime) begin
                atime_q <= atime_wr_word;
            end
        end
    end

    // digit ranges that a tick must never break
    wire time_valid = (time_q.hours_tens <= 2'h2) && (time_q.hours_ones <= 4'h9)
        && (time_q.minutes_tens <= 3'h5) && (time_q.minutes_ones <= 4'h9)
        && (time_q.seconds_tens <= 3'h5) && (time_q.seconds_ones <= 4'h9);

    chk_rpt_decrement: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fire && !wr_alm && (alarm_repeat_count != 8'h00)
        |=> alm_q[7:0] == $past(alm_q[7:0]) - 8'h01
    ) else $error("repeat count did not step down");

    chk_chime_wrap: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fire && !wr_alm && (alarm_repeat_count == 8'h00) && alm_q[CHIME]
        |=> alm_q[7:0] == 8'hff && alm_q[EN]
    ) else $error("chime did not wrap the repeat count");

    chk_enable_cleared: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fire && !wr_alm && (alarm_repeat_count == 8'h00) && !alm_q[CHIME]
        |=> !alm_q[EN]
    ) else $error("alarm enable not cleared after last repeat");

    chk_count_stops: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fire && !wr_alm && (alarm_repeat_count == 8'h00) && !alm_q[CHIME]
        |=> alm_q[7:0] == 8'h00
    ) else $error("repeat count moved past zero");

    chk_locked_time: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_time && !clock_write_enable && !sec_tick |=> time_q == $past(time_q)
    ) else $error("time changed by a locked write");

    chk_locked_date: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_date && !clock_write_enable && !sec_tick |=> date_q == $past(date_q)
    ) else $error("date changed by a locked write");

    chk_tick_keeps_bcd: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sec_tick && !wr_time_ok && time_valid |=> time_valid
    ) else $error("second tick left a digit out of range");

    chk_event_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        alarm_event_o |=> !alarm_event_o
    ) else $error("alarm event longer than one cycle");

    chk_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o
    ) else $error("ack held for more than one cycle");
endmodule

// [rtcc_core_tb_top.sv]
`timescale 1ns/100ps
module rtcc_core_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd, rd2;
    logic ack_o, alarm_event_o;
    int n_fail = 0, comparisons = 0, n_evt = 0, base = 0;
    always #2.5 clk_i = ~clk_i;
    // a 100-clock half second leaves part of each period outside the sync window
    rtcc_core #(.HALF_SEC_CYC(100)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .alarm_event_o(alarm_event_o)
    );
    always @(posedge clk_i) begin
        if (alarm_event_o === 1'b1) begin
            n_evt <= n_evt + 1;
        end
    end
    task wrap_up;
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // request held until the edge that samples ack; data taken at that edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        for (i = 0; i < 32; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) begin
                break;
            end
        end
        if (i == 32) begin
            n_fail++;
            wrap_up();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task rd_alarm;
        int k;
        bus(1'b0, rtcc_pkg::RTCC_OFF_ALARM, 32'h0);
        for (k = 0; k < 8; k++) begin
            rd2 = rd;
            bus(1'b0, rtcc_pkg::RTCC_OFF_ALARM, 32'h0);
            if (rd === rd2) begin
                break;
            end
        end
    endtask
    // alarm fields are only written while the module is off
    task run(input logic [31:0] alarm, input int n);
        bus(1'b1, rtcc_pkg::RTCC_OFF_ALARM, alarm);
        base = n_evt;
        bus(1'b1, rtcc_pkg::RTCC_OFF_CTRL, 32'h0000_8000);
        repeat (n) @(posedge clk_i);
        bus(1'b1, rtcc_pkg::RTCC_OFF_CTRL, 32'h0000_0008);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b1, rtcc_pkg::RTCC_OFF_CTRL, 32'h0000_0008);
        // junk in every unimplemented bit must read back as zero
        bus(1'b1, rtcc_pkg::RTCC_OFF_TIME, 32'he3d9_d9ff);
        bus(1'b0, rtcc_pkg::RTCC_OFF_TIME, 32'h0);
        chk("time", 32'h2359_5900, rd);
        bus(1'b1, rtcc_pkg::RTCC_OFF_DATE, 32'h99f2_f1fe);
        bus(1'b0, rtcc_pkg::RTCC_OFF_DATE, 32'h0);
        chk("date", 32'h9912_3106, rd);
        bus(1'b1, rtcc_pkg::RTCC_OFF_ALARM, 32'h0000_00ff);
        bus(1'b0, rtcc_pkg::RTCC_OFF_ALARM, 32'h0);
        chk("repeat", 32'h0000_00ff, rd & 32'h0000_00ff);
        bus(1'b1, rtcc_pkg::RTCC_OFF_CTRL, 32'h0000_0000);
        bus(1'b1, rtcc_pkg::RTCC_OFF_TIME, 32'h0000_0000);
        bus(1'b1, rtcc_pkg::RTCC_OFF_DATE, 32'h0000_0000);
        bus(1'b0, rtcc_pkg::RTCC_OFF_TIME, 32'h0);
        chk("locked time", 32'h2359_5900, rd);
        bus(1'b0, rtcc_pkg::RTCC_OFF_DATE, 32'h0);
        chk("locked date", 32'h9912_3106, rd);
        // one second carries through every field; alarm left disabled
        run(32'h0000_00ff, 250);
        chk("no event", 32'h0, n_evt - base);
        bus(1'b0, rtcc_pkg::RTCC_OFF_TIME, 32'h0);
        chk("rolled time", 32'h0000_0000, rd);
        bus(1'b0, rtcc_pkg::RTCC_OFF_DATE, 32'h0);
        chk("rolled date", 32'h0001_0100, rd);
        // count 1 fires twice, then enable drops and the count stays at zero
        run(32'h0000_8001, 450);
        chk("two events", 32'h2, n_evt - base);
        rd_alarm();
        chk("spent alarm", 32'h0000_0000, rd);
        // chime wraps zero to the top and keeps the alarm enabled
        run(32'h0000_c000, 150);
        chk("chime event", 32'h1, n_evt - base);
        rd_alarm();
        chk("chime wrap", 32'h0000_c0ff, rd);
        // minute mask matches the alarm seconds only
        bus(1'b1, rtcc_pkg::RTCC_OFF_TIME, 32'h0000_0000);
        bus(1'b1, rtcc_pkg::RTCC_OFF_ATIME, 32'hffff_ffff);
        bus(1'b0, rtcc_pkg::RTCC_OFF_ATIME, 32'h0);
        chk("alarm time", 32'h3f7f_7f00, rd);
        bus(1'b1, rtcc_pkg::RTCC_OFF_ATIME, 32'h0000_0200);
        run(32'h0000_8300, 650);
        chk("minute event", 32'h1, n_evt - base);
        rd_alarm();
        chk("minute alarm", 32'h0000_0300, rd);
        bus(1'b0, rtcc_pkg::RTCC_OFF_TIME, 32'h0);
        chk("three seconds", 32'h0000_0300, rd);
        wrap_up();
    end
endmodule
